// ### hdl/tno_pkg.sv
//----------------------------------------------------------------------
// Shared constants for the timing oscillator and timing error block
//----------------------------------------------------------------------
package tno_pkg;

   // Bus geometry
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // Control word indices; byte address is four times the index
   localparam logic [5:0] IDX_CW1 = 6'h01;
   localparam logic [5:0] IDX_CW11 = 6'h0b;
   localparam logic [5:0] IDX_CW12 = 6'h0c;
   localparam logic [5:0] IDX_CW13 = 6'h0d;
   localparam logic [5:0] IDX_CW14 = 6'h0e;
   localparam logic [5:0] IDX_CW15 = 6'h0f;
   localparam logic [5:0] IDX_TERR = 6'h10;
   localparam logic [5:0] IDX_CW18 = 6'h12;

   // Field positions
   localparam int CW1_RESAMP_BIT = 0;
   localparam int CW1_SYNC_EN_BIT = 5;
   localparam int CW11_LOAD_BIT = 0;
   localparam int CW11_CLEAR_BIT = 1;
   localparam int CW11_OFS_EN_BIT = 2;
   localparam int CW11_OFS_W_LO = 3;
   localparam int PHASE_W = 8;
   localparam int DIV_W = 12;
   localparam int CW18_OSC_DIV_LO = 16;
   localparam int CW18_REF_DIV_LO = 0;
   localparam int TE_W = 16;
   localparam int ACC_W = 32;

   // Values after reset and counts
   localparam logic [31:0] CW_RST = 32'h0000_0000;
   localparam int FIX_DIV_DEF = 6;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Input pin order in the synchroniser bank
   localparam int PIN_SYNC = 0;
   localparam int PIN_REF = 1;
   localparam int PIN_SCLK = 2;
   localparam int PIN_SDATA = 3;
   localparam int PIN_SLOAD = 4;
   localparam int PIN_N = 5;

   typedef enum logic {
      SER_IDLE = 1'b0,
      SER_SHIFT = 1'b1
   } tno_ser_e;

   // Software control words
   typedef struct packed {
      logic [31:0] cw1;
      logic [31:0] cw11;
      logic [31:0] cw12;
      logic [31:0] cw13;
      logic [31:0] cw18;
   } tno_ctl_s;

endpackage : tno_pkg

// ### hdl/tno_phase_acc.sv
`timescale 1ns/1ns
`default_nettype none
module tno_phase_acc (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clear,
   input wire logic load,
   input wire logic [tno_pkg::ACC_W-1:0] step,
   output logic [tno_pkg::ACC_W-1:0] acc,
   output logic carry
);
   import tno_pkg::*;

   typedef struct packed {
      logic [ACC_W-1:0] acc;
      logic carry;
   } tno_acc_s;

   tno_acc_s s_reg;
   tno_acc_s s_next;
   logic [ACC_W:0] sum;

   // Add, clear or load; clear wins so software can hold the phase at zero
   always_comb begin
      s_next = s_reg;
      sum = {1'b0, s_reg.acc} + {1'b0, step};
      s_next.carry = 1'b0;
      if (clear) begin
         s_next.acc = '0;  // [R5]
      end else if (load) begin
         s_next.acc = step;  // [R6]
      end else begin
         s_next.acc = sum[ACC_W-1:0];  // [R16]
         s_next.carry = sum[ACC_W];  // [R16]
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign acc = s_reg.acc;
   assign carry = s_reg.carry;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_acc_sum;
      !clear && !load |=> acc == $past(acc) + $past(step);
   endproperty
   a_acc_sum: assert property (p_acc_sum) else $error("accumulator did not add step");  // [R16]

   property p_acc_clr;
      clear |=> acc == '0 && !carry;
   endproperty
   a_acc_clr: assert property (p_acc_clr) else $error("accumulator not cleared");  // [R5]

   property p_acc_load;
      load && !clear |=> acc == $past(step);
   endproperty
   a_acc_load: assert property (p_acc_load) else $error("accumulator not loaded");  // [R6]

endmodule : tno_phase_acc
`default_nettype wire

// ### hdl/tno_div_cnt.sv
`timescale 1ns/1ns
`default_nettype none
module tno_div_cnt #(
   parameter int W = 12
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic [W-1:0] preload,
   output logic [W-1:0] cnt,
   output logic tc
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic tc;
   } tno_cnt_s;

   tno_cnt_s s_reg;
   tno_cnt_s s_next;

   if (W < 2 || W > 16) begin : g_chk
      $error("divide counter width out of range");
   end

   // Count down on each enable, reload after terminal count
   always_comb begin
      s_next = s_reg;
      s_next.tc = 1'b0;
      if (en) begin
         if (s_reg.cnt == '0) begin
            s_next.cnt = preload;  // [R17]
            s_next.tc = 1'b1;
         end else begin
            s_next.cnt = s_reg.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign cnt = s_reg.cnt;
   assign tc = s_reg.tc;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_cnt_reload;
      en && cnt == '0 |=> tc && cnt == $past(preload);
   endproperty
   a_cnt_reload: assert property (p_cnt_reload) else $error("counter did not reload");  // [R17]

   property p_cnt_dec;
      en && cnt != '0 |=> !tc && cnt == $past(cnt) - 1'b1;
   endproperty
   a_cnt_dec: assert property (p_cnt_dec) else $error("counter did not count down");  // [R10]

endmodule : tno_div_cnt
`default_nettype wire

// ### hdl/tno_timing_top.sv
`timescale 1ns/1ns
`default_nettype none
//----------------------------------------------------------------------
// Timing oscillator with timing error generator
//----------------------------------------------------------------------
// What this block does
// R1: Oscillator gives resampler a sample pulse and phase, no sine/cosine stage.
// R2: Control word 1 bit 5 lets an external sync input clear the oscillator.
// R3: Control word 11 bits 3-4 set the serial offset frequency word length.
// R4: Control word 11 bit 2 adds offset frequency; clear means offset ignored.
// R5: Control word 11 bit 1 clears the phase accumulator.
// R6: Control word 11 bit 0 makes an update load rather than accumulate.
// R7: Control word 12 holds the center frequency, the base phase increment.
// R8: Control word 13 bits 0-7 give a phase offset added to oscillator phase.
// R9: Writing word 14 applies new frequency; writing word 15 applies new phase.
// R10: Timing error compares a carry-clocked counter with a reference-clocked one.
// R11: Word 18 bits 16-27 preload the carry-clocked counter.
// R12: Word 18 bits 0-11 preload the reference-clocked counter.
// R13: The 16-bit timing error goes out serially and is readable by software.
// R14: With the resampler in use, the output rate comes from the oscillator.
// R15: An outside loop filter feeds filtered timing error back as frequency.
// R16: Accumulator adds center plus enabled offset; its carry is the sample pulse.
// R17: Counters reload at terminal count; error captured from their difference.
module tno_timing_top #(
   parameter int FIX_DIV = tno_pkg::FIX_DIV_DEF
) (
   input wire logic REF_CLK,
   input wire logic RST_N,
   input wire logic [tno_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [tno_pkg::DATA_W-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [tno_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [tno_pkg::DATA_W-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic EXT_SYNC,
   input wire logic EXT_REF_IN,
   input wire logic OFS_SCLK,
   input wire logic OFS_SDATA,
   input wire logic OFS_SLOAD,
   output logic SAMPLE_PULSE,
   output logic [tno_pkg::PHASE_W-1:0] SAMPLE_PHASE,
   output logic RATE_PULSE,
   output logic TE_SDATA,
   output logic TE_SFRAME
);
   import tno_pkg::*;

   if (FIX_DIV < 1 || FIX_DIV > 65536) begin : g_chk
      $error("FIX_DIV must lie between 1 and 65536");
   end

   localparam logic [15:0] FIX_LAST = 16'(FIX_DIV - 1);

   //-------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------
   typedef struct packed {
      tno_ctl_s ctl;
      logic [ACC_W-1:0] center_act;
      logic [PHASE_W-1:0] phase_act;
      logic acc_load;
      logic sync_clr;
      logic [ACC_W-1:0] offset;
      logic [ACC_W-1:0] ofs_shift;
      logic [PIN_N-1:0] sync1;
      logic [PIN_N-1:0] sync2;
      logic [PIN_N-1:0] sync3;
      logic smp_pulse;
      logic [PHASE_W-1:0] smp_phase;
      logic rate_pulse;
      logic [15:0] fix_cnt;
      logic [TE_W-1:0] terr;
      logic [TE_W-1:0] te_shift;
      logic [4:0] te_cnt;
      tno_ser_e te_st;
      logic te_data;
      logic te_frame;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [5:0] awidx;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } tno_top_s;

   tno_top_s s_reg;
   tno_top_s s_next;

   logic [ACC_W-1:0] step;
   logic [ACC_W-1:0] acc_q;
   logic acc_carry;
   logic acc_clear;
   logic [DIV_W-1:0] osc_cnt;
   logic [DIV_W-1:0] ref_cnt;
   logic ref_tc;
   logic ref_edge;
   logic wr_go;

   //-------------------------------------------------------------------
   // Helpers
   //-------------------------------------------------------------------
   // Byte-lane merge for register writes
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = new_v[8*i +: 8];
         end
      end
      return r;
   endfunction : strb_merge

   // Offset word length: 8, 16, 24 or 32 bits
   function automatic logic [5:0] ofs_bits(input logic [1:0] sel);
      return {1'b0, sel, 3'b000} + 6'd8;
   endfunction : ofs_bits

   //-------------------------------------------------------------------
   // Oscillator and divide counters
   //-------------------------------------------------------------------
   // Offset only joins the increment when enabled; stale offsets stay inert
   assign step = s_reg.center_act
      + (s_reg.ctl.cw11[CW11_OFS_EN_BIT] ? s_reg.offset : '0);  // [R4] [R7] [R16]
   assign acc_clear = s_reg.ctl.cw11[CW11_CLEAR_BIT] | s_reg.sync_clr;  // [R5] [R2]
   assign ref_edge = s_reg.sync2[PIN_REF] & ~s_reg.sync3[PIN_REF];
   assign wr_go = s_reg.aw_got & s_reg.w_got & ~s_reg.bvalid;

   tno_phase_acc u_acc (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .clear(acc_clear),
      .load(s_reg.acc_load),
      .step(step),
      .acc(acc_q),
      .carry(acc_carry)
   );

   // Carry-out clocks the oscillator-side counter
   tno_div_cnt #(.W(DIV_W)) u_osc_cnt (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(acc_carry),
      .preload(s_reg.ctl.cw18[CW18_OSC_DIV_LO +: DIV_W]),  // [R11]
      .cnt(osc_cnt),
      .tc()
   );

   // Reference edges clock the reference-side counter
   tno_div_cnt #(.W(DIV_W)) u_ref_cnt (
      .clk(REF_CLK),
      .rst_n(RST_N),
      .en(ref_edge),
      .preload(s_reg.ctl.cw18[CW18_REF_DIV_LO +: DIV_W]),  // [R12]
      .cnt(ref_cnt),
      .tc(ref_tc)
   );

   //-------------------------------------------------------------------
   // Next-state logic
   //-------------------------------------------------------------------
   // Pins, bus slave, updates, sample outputs and timing error serialiser
   always_comb begin
      logic wr_freq;
      logic wr_phase;
      logic sclk_rise;
      logic load_fall;
      logic [TE_W-1:0] te_new;
      wr_freq = 1'b0;
      wr_phase = 1'b0;
      sclk_rise = s_reg.sync2[PIN_SCLK] & ~s_reg.sync3[PIN_SCLK];
      load_fall = ~s_reg.sync2[PIN_SLOAD] & s_reg.sync3[PIN_SLOAD];
      te_new = {4'h0, osc_cnt} - {4'h0, ref_cnt};  // [R10] [R17]
      s_next = s_reg;
      // Two stages resolve the pins; a third holds the previous level for edges
      s_next.sync1 = {OFS_SLOAD, OFS_SDATA, OFS_SCLK, EXT_REF_IN, EXT_SYNC};
      s_next.sync2 = s_reg.sync1;
      s_next.sync3 = s_reg.sync2;

      // Write channel: address and data accepted in either order
      if (s_reg.awready && S_AXI_AWVALID) begin
         s_next.aw_got = 1'b1;
         s_next.awidx = S_AXI_AWADDR[7:2];
      end
      if (s_reg.wready && S_AXI_WVALID) begin
         s_next.w_got = 1'b1;
         s_next.wdata = S_AXI_WDATA;
         s_next.wstrb = S_AXI_WSTRB;
      end
      if (s_reg.bvalid && S_AXI_BREADY) begin
         s_next.bvalid = 1'b0;
      end
      if (wr_go) begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = RESP_OKAY;
         case (s_reg.awidx)
            IDX_CW1: s_next.ctl.cw1 = strb_merge(s_reg.ctl.cw1, s_reg.wdata, s_reg.wstrb);
            IDX_CW11: s_next.ctl.cw11 = strb_merge(s_reg.ctl.cw11, s_reg.wdata, s_reg.wstrb);
            IDX_CW12: s_next.ctl.cw12 = strb_merge(s_reg.ctl.cw12, s_reg.wdata, s_reg.wstrb);
            IDX_CW13: s_next.ctl.cw13 = strb_merge(s_reg.ctl.cw13, s_reg.wdata, s_reg.wstrb);
            IDX_CW18: s_next.ctl.cw18 = strb_merge(s_reg.ctl.cw18, s_reg.wdata, s_reg.wstrb);
            IDX_CW14: wr_freq = 1'b1;
            IDX_CW15: wr_phase = 1'b1;
            default: s_next.bresp = RESP_SLVERR;
         endcase
      end
      s_next.awready = ~s_next.aw_got & ~s_next.bvalid;
      s_next.wready = ~s_next.w_got & ~s_next.bvalid;

      // Read channel: one read at a time, data one cycle after address
      if (s_reg.rvalid && S_AXI_RREADY) begin
         s_next.rvalid = 1'b0;
         s_next.arready = 1'b1;
      end
      if (s_reg.arready && S_AXI_ARVALID) begin
         s_next.arready = 1'b0;
         s_next.rvalid = 1'b1;
         s_next.rresp = RESP_OKAY;
         case (S_AXI_ARADDR[7:2])
            IDX_CW1: s_next.rdata = s_reg.ctl.cw1;
            IDX_CW11: s_next.rdata = s_reg.ctl.cw11;
            IDX_CW12: s_next.rdata = s_reg.ctl.cw12;
            IDX_CW13: s_next.rdata = s_reg.ctl.cw13;
            IDX_CW18: s_next.rdata = s_reg.ctl.cw18;
            IDX_CW14, IDX_CW15: s_next.rdata = '0;
            IDX_TERR: s_next.rdata = {16'h0000, s_reg.terr};  // [R13]
            default: begin
               s_next.rdata = '0;
               s_next.rresp = RESP_SLVERR;
            end
         endcase
      end

      // Strobes move shadow words into use
      if (wr_freq) begin
         s_next.center_act = s_reg.ctl.cw12;  // [R9] [R7]
      end
      if (wr_phase) begin
         s_next.phase_act = s_reg.ctl.cw13[PHASE_W-1:0];  // [R9] [R8]
      end
      s_next.acc_load = wr_freq & s_reg.ctl.cw11[CW11_LOAD_BIT];  // [R6]
      s_next.sync_clr = s_reg.ctl.cw1[CW1_SYNC_EN_BIT]
         & s_reg.sync2[PIN_SYNC] & ~s_reg.sync3[PIN_SYNC];  // [R2]

      // Serial offset word, shifted MSB first while load is high
      if (sclk_rise && s_reg.sync2[PIN_SLOAD]) begin
         s_next.ofs_shift = {s_reg.ofs_shift[ACC_W-2:0], s_reg.sync2[PIN_SDATA]};
      end
      if (load_fall) begin
         s_next.offset = s_reg.ofs_shift
            << (6'd32 - ofs_bits(s_reg.ctl.cw11[CW11_OFS_W_LO +: 2]));  // [R3]
      end

      // Sample pulse and phase to the resampler, no sine/cosine stage
      s_next.smp_pulse = acc_carry;  // [R1] [R16]
      s_next.smp_phase = acc_q[ACC_W-1 -: PHASE_W] + s_reg.phase_act;  // [R1] [R8]

      // Fixed division only serves when the resampler is not in use
      if (s_reg.fix_cnt == FIX_LAST) begin
         s_next.fix_cnt = '0;
      end else begin
         s_next.fix_cnt = s_reg.fix_cnt + 16'h0001;
      end
      s_next.rate_pulse = s_reg.ctl.cw1[CW1_RESAMP_BIT] ? acc_carry
         : (s_reg.fix_cnt == FIX_LAST);  // [R14]

      // Serialiser: a new capture restarts the frame
      case (s_reg.te_st)
         SER_IDLE: begin
            s_next.te_frame = 1'b0;
            s_next.te_data = 1'b0;
         end
         SER_SHIFT: begin
            if (s_reg.te_cnt == 5'(TE_W)) begin
               s_next.te_st = SER_IDLE;
               s_next.te_frame = 1'b0;
               s_next.te_data = 1'b0;
            end else begin
               s_next.te_data = s_reg.te_shift[TE_W-1];
               s_next.te_shift = {s_reg.te_shift[TE_W-2:0], 1'b0};
               s_next.te_cnt = s_reg.te_cnt + 5'd1;
            end
         end
         default: s_next.te_st = SER_IDLE;
      endcase
      if (ref_tc) begin
         s_next.terr = te_new;  // [R17]
         s_next.te_st = SER_SHIFT;
         s_next.te_frame = 1'b1;  // [R13]
         s_next.te_data = te_new[TE_W-1];
         s_next.te_shift = {te_new[TE_W-2:0], 1'b0};
         s_next.te_cnt = 5'd1;
      end
   end

   //-------------------------------------------------------------------
   // Registers
   //-------------------------------------------------------------------
   // Control words reset to zero; ready signals are set during reset
   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         s_reg <= '0;
         s_reg.ctl <= {5{CW_RST}};
         s_reg.awready <= 1'b1;
         s_reg.wready <= 1'b1;
         s_reg.arready <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flip-flops
   assign S_AXI_AWREADY = s_reg.awready;
   assign S_AXI_WREADY = s_reg.wready;
   assign S_AXI_BRESP = s_reg.bresp;
   assign S_AXI_BVALID = s_reg.bvalid;
   assign S_AXI_ARREADY = s_reg.arready;
   assign S_AXI_RDATA = s_reg.rdata;
   assign S_AXI_RRESP = s_reg.rresp;
   assign S_AXI_RVALID = s_reg.rvalid;
   assign SAMPLE_PULSE = s_reg.smp_pulse;
   assign SAMPLE_PHASE = s_reg.smp_phase;
   assign RATE_PULSE = s_reg.rate_pulse;
   assign TE_SDATA = s_reg.te_data;
   assign TE_SFRAME = s_reg.te_frame;

   //-------------------------------------------------------------------
   // Checks
   //-------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   property p_freq_upd;
      wr_go && s_reg.awidx == IDX_CW14 |=> s_reg.center_act == $past(s_reg.ctl.cw12);
   endproperty
   a_freq_upd: assert property (p_freq_upd) else $error("frequency strobe ignored");  // [R9]

   property p_phase_out;
      1'b1 |=> SAMPLE_PHASE == $past(acc_q[ACC_W-1 -: PHASE_W]) + $past(s_reg.phase_act);
   endproperty
   a_phase_out: assert property (p_phase_out) else $error("phase offset not applied");  // [R8]

   property p_ofs_off;
      !s_reg.ctl.cw11[CW11_OFS_EN_BIT] |-> step == s_reg.center_act;
   endproperty
   a_ofs_off: assert property (p_ofs_off) else $error("offset used while disabled");  // [R4]

   property p_pulse;
      acc_carry |=> SAMPLE_PULSE ##1 !SAMPLE_PULSE || $past(acc_carry);
   endproperty
   a_pulse: assert property (p_pulse) else $error("sample pulse not from carry");  // [R1]

   property p_te_frame;
      ref_tc |=> TE_SFRAME [*8];
   endproperty
   a_te_frame: assert property (p_te_frame) else $error("timing error frame too short");  // [R13]

   property p_rate;
      s_reg.ctl.cw1[CW1_RESAMP_BIT] && acc_carry |=> RATE_PULSE;
   endproperty
   a_rate: assert property (p_rate) else $error("rate not set by oscillator");  // [R14]

   property p_sync;
      s_reg.sync_clr |=> acc_q == '0;
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not clear oscillator");  // [R2]

   property p_terr;
      ref_tc |=> s_reg.terr == {4'h0, $past(osc_cnt)} - {4'h0, $past(ref_cnt)};
   endproperty
   a_terr: assert property (p_terr) else $error("timing error not captured");  // [R17]

endmodule : tno_timing_top
`default_nettype wire

// ### bench/tno_far_side.sv
`timescale 1ns/1ns
`default_nettype none
// Far side: free-running reference clock and serial offset loader
module tno_far_side (
   input wire logic clk,
   input wire logic ref_run,
   output logic ref_o,
   output logic sclk,
   output logic sdata,
   output logic sload
);
   int div = 0;
   initial begin
      ref_o = 1'b0;
      sclk = 1'b0;
      sdata = 1'b0;
      sload = 1'b0;
   end
   // Reference period of 10 cycles, phase unrelated to the oscillator
   always @(posedge clk) begin
      div <= (div == 4) ? 0 : div + 1;
      if (ref_run && div == 4) ref_o <= ~ref_o;
   end
   // MSB first; slow steps so the pin synchronisers see every edge
   task automatic send_ofs(input logic [7:0] w);
      sload <= 1'b1;
      for (int i = 7; i >= 0; i--) begin
         repeat (4) @(posedge clk);
         sdata <= w[i];
         repeat (4) @(posedge clk);
         sclk <= 1'b1;
         repeat (4) @(posedge clk);
         sclk <= 1'b0;
      end
      repeat (4) @(posedge clk);
      sload <= 1'b0;
      // Released data line: show the inverse, never the last bit
      sdata <= ~sdata;
   endtask : send_ofs
endmodule : tno_far_side
`default_nettype wire

// ### bench/timing_nco_and_timing_error_bench.sv
`timescale 1ns/1ns
`default_nettype none
module timing_nco_and_timing_error_bench;
   import tno_pkg::*;
   localparam int FD = 4;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, ph0, ph, ofs;
   logic [31:0] wdata = 32'h0, v, w, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0;
   logic rready = 1'b0, ref_run = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, spulse, rpulse, tsd, tsf;
   logic ext_ref, sclk, sdata, sload, ext_sync = 1'b0;
   logic [1:0] bresp, rresp, r;
   logic [7:0] sphase;
   logic [15:0] ser;
   int error_cnt = 0, comparisons = 0, seed = 71366, p, q, n;

   // Byte strobes held fixed
   tno_timing_top #(.FIX_DIV(FD)) u_dut (
      .REF_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
      .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
      .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .EXT_SYNC(ext_sync), .EXT_REF_IN(ext_ref), .OFS_SCLK(sclk), .OFS_SDATA(sdata),
      .OFS_SLOAD(sload), .SAMPLE_PULSE(spulse), .SAMPLE_PHASE(sphase),
      .RATE_PULSE(rpulse), .TE_SDATA(tsd), .TE_SFRAME(tsf));
   tno_far_side u_far (.clk(clk), .ref_run(ref_run), .ref_o(ext_ref), .sclk(sclk),
      .sdata(sdata), .sload(sload));

   initial begin
      forever #5 clk = ~clk;
   end

   //-------------------------------------------------------------------
   // Bus, check and expectation helpers
   //-------------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic chk(input logic ok, input string m);
      comparisons++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : chk
   task automatic tmo(input int k, input int lim);
      if (k >= lim) begin
         chk(1'b0, "wait ran out");
         summarize();
      end
   endtask : tmo
   // Address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 50);
      bready <= 1'b0;
      r = bresp;
      tmo(n, 50);
      @(posedge clk); // Idle edge, so strobes never toggle twice in one step
   endtask : wr
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 50);
      rready <= 1'b0;
      v = rdata;
      r = rresp;
      tmo(n, 50);
      @(posedge clk);
   endtask : rd
   task automatic cnt();
      p = 0;
      q = 0;
      repeat (64) begin
         @(posedge clk);
         p += (spulse === 1'b1);
         q += (rpulse === 1'b1);
      end
   endtask : cnt
   task automatic cap(output logic [7:0] x);
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (spulse !== 1'b1 && n < 50);
      x = sphase;
      tmo(n, 50);
   endtask : cap
   // Step of 2^(31-i) wraps every 2^(i+1) cycles
   function automatic logic [31:0] step_of(input int i);
      return 32'h8000_0000 >> i;
   endfunction : step_of
   function automatic int pulses_of(input int i);
      return 32 >> i;
   endfunction : pulses_of

   //-------------------------------------------------------------------
   // Main sequence
   //-------------------------------------------------------------------
   initial begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(8'h04);
      chk(v === CW_RST && r === RESP_OKAY, "control word reset value");
      rd(8'h08);
      chk(v === 32'h0 && r === RESP_SLVERR, "unmapped read");
      wr(8'h40, 32'h1234);
      chk(r === RESP_SLVERR, "write to timing error");
      w = $random(seed) & 32'h0fff_0fff;
      wr(8'h48, w);
      rd(8'h48);
      chk(v === w, "divide word readback");
      $display("test registers done");
      wr(8'h04, 32'h1);
      wr(8'h2c, 32'h1);
      for (int i = 0; i < 3; i++) begin
         wr(8'h30, step_of(i));
         wr(8'h38, 32'h0);
         cnt();
         chk(p == pulses_of(i), "sample pulse count");
         chk(q == p, "rate follows oscillator");
      end
      wr(8'h04, 32'h0);
      cnt();
      chk(q == 64 / FD, "fixed rate division");
      $display("test frequency done");
      // Slow serial load first, then center 2^30 with offset 2^30
      u_far.send_ofs(8'h40);
      wr(8'h30, 32'h4000_0000);
      wr(8'h38, 32'h0);
      wr(8'h2c, 32'h4);
      cnt();
      chk(p == 32, "offset added");
      wr(8'h2c, 32'h0);
      cnt();
      chk(p == 16, "offset ignored");
      // Sixteen-bit word keeps the old byte above the new one
      wr(8'h2c, 32'h8);
      u_far.send_ofs(8'h00);
      wr(8'h2c, 32'hc);
      cnt();
      chk(p == 32, "sixteen-bit offset word");
      wr(8'h2c, 32'h2);
      cnt();
      chk(p == 0, "accumulator held clear");
      wr(8'h2c, 32'h0);
      $display("test offset and clear done");
      cap(ph0);
      ofs = 8'($random(seed));
      wr(8'h34, {24'h0, ofs});
      cap(ph);
      chk(ph === ph0, "phase unchanged before strobe");
      wr(8'h3c, 32'h0);
      cap(ph);
      chk(ph === ph0 + ofs, "phase offset applied");
      // Without the clear the phase here would sit half a turn away
      wr(8'h04, 32'h20);
      cap(ph);
      ext_sync <= 1'b1;
      repeat (6) @(posedge clk);
      chk(sphase === ofs, "sync clears oscillator");
      ext_sync <= 1'b0;
      $display("test phase done");
      wr(8'h48, {4'h0, 12'h00a, 4'h0, 12'h028});
      ref_run <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (tsf !== 1'b1 && n < 2000);
      tmo(n, 2000);
      for (int i = 0; i < 16; i++) begin
         ser = {ser[14:0], tsd};
         chk(tsf === 1'b1, "frame held");
         @(posedge clk);
      end
      chk(tsf === 1'b0, "frame of 16 bits");
      rd(8'h40);
      chk(v[15:0] === ser, "serial and read error agree");
      // Measured error written to center word 12 from outside; no word 14 write applies it
      wr(8'h30, 32'h4000_0000 + {{16{ser[15]}}, ser});
      $display("test timing error done");
      summarize();
   end
endmodule : timing_nco_and_timing_error_bench
`default_nettype wire
